/* File: sim/host_wdata_model.sv */
`timescale 1ns/10ps
`include "burst_sram_consts.svh"

module host_wdata_model (
    // clock and controls as the memory sees them
    input wire logic clock,
    input wire logic clock_enable_n,
    input wire logic load_or_advance,
    input wire logic read_write_n,
    input wire logic selected,
    // word belonging to the current address cycle
    input wire logic [`SRAM_DATA_W-1:0] word,
    // write data onto the bus
    output logic [`SRAM_DATA_W-1:0] data_in
);
    logic bw_q = 1'b0;
    logic [1:0] w_q = 2'h0;
    logic [`SRAM_DATA_W-1:0] d0_q = '0;
    logic [`SRAM_DATA_W-1:0] d1_q = '0;

    // word trails its address by two enabled edges; a disabled edge moves nothing
    always @(posedge clock) begin
        if (!clock_enable_n) begin
            if (!load_or_advance) begin
                bw_q <= selected & !read_write_n;
            end
            w_q <= {w_q[0], load_or_advance ? bw_q : selected & !read_write_n};
            d0_q <= word;
            d1_q <= d0_q;
        end
    end

    // outside a write slot the bus shows the inverted word, so stale data cannot match
    assign data_in = w_q[1] ? d1_q : ~d1_q;
endmodule : host_wdata_model

/* File: sim/pipelined_burst_sram_bench.sv */
`timescale 1ns/10ps
`include "burst_sram_consts.svh"

module pipelined_burst_sram_bench;
    logic clock = 1'b0, rst_n = 1'b0, cen_n = 1'b0, lad = 1'b0, rw = 1'b1, bos = 1'b0;
    logic oe_n = 1'b0, oe_next = 1'b0, doe;
    logic [2:0] cs = 3'h6;
    logic [3:0] be = 4'hF;
    logic [16:0] a = '0, base, cur;
    logic [35:0] wd = '0, din, dout;
    logic [35:0] m [logic [16:0]];
    logic e_rd [0:2] = '{1'b0, 1'b0, 1'b0};
    logic [35:0] e_d [0:2];
    int dir = 0, cnt = 0, miscompares = 0, num_checks = 0, cycles = 0;
    localparam logic [2:0] SEL = 3'h2;

    pipelined_burst_sram i_pipelined_burst_sram (
        .clock(clock), .rst_n(rst_n), .clock_enable_n(cen_n), .load_or_advance(lad),
        .read_write_n(rw), .byte_write_enable_n(be), .address(a),
        .chip_select_low_a_n(cs[2]), .chip_select_high_or_low_b(cs[1]),
        .chip_select_low_c_n(cs[0]), .burst_order_select(bos), .output_enable_n(oe_n),
        .data_in(din), .data_out(dout), .data_oe(doe));
    host_wdata_model i_host_wdata_model (
        .clock(clock), .clock_enable_n(cen_n), .load_or_advance(lad), .read_write_n(rw),
        .selected(cs == SEL), .word(wd), .data_in(din));

    // ****************************************************************
    // compares and the cycle driver
    // ****************************************************************
    task chk_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk_bit

    task chk_word(input logic [35:0] got, input logic [35:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk_word

    // judges the slot two enabled edges old, then drives and models one edge
    task cyc(input logic c, input logic l, input logic r, input logic [2:0] s,
             input logic [16:0] ad, input logic [3:0] b, input logic [35:0] w);
        @(negedge clock);
        chk_bit(doe, e_rd[2] & !oe_n, "bus drive");
        // the read word stands in the register whether or not the drivers are on
        if (e_rd[2]) chk_word(dout, e_d[2], "read word");
        cen_n = c;
        lad = l;
        rw = r;
        cs = s;
        a = ad;
        be = b;
        wd = w;
        oe_n = oe_next;
        if (!c) begin
            if (!l) begin
                dir = (s != SEL) ? 0 : (r ? 1 : 2);
                base = ad;
                cnt = 0;
            end else if (dir != 0) cnt++;
            cur = {base[16:2], bos === 1'b0 ? base[1:0] + cnt[1:0] : base[1:0] ^ cnt[1:0]};
            if (dir == 2) for (int i = 0; i < 4; i++) if (!b[i]) m[cur][9*i +: 9] = w[9*i +: 9];
            e_rd[2] = e_rd[1];
            e_d[2] = e_d[1];
            e_rd[1] = e_rd[0];
            e_d[1] = e_d[0];
            e_rd[0] = (dir == 1);
            e_d[0] = (dir == 1) ? m[cur] : '0;
        end
        @(posedge clock);
    endtask : cyc

    task flush;
        repeat (3) cyc(0, 0, 1, 3'h6, '0, 4'hF, '0);
    endtask : flush

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task t_rw;
        cyc(0, 0, 0, SEL, 17'h00010, 4'h0, 36'h123456789);
        cyc(0, 0, 0, SEL, 17'h00011, 4'h0, 36'hABCDEF012);
        cyc(0, 0, 1, SEL, 17'h00010, 4'h0, 36'h0);
        cyc(0, 0, 0, SEL, 17'h00010, 4'h5, 36'h0FF0FF0FF);
        cyc(0, 0, 1, SEL, 17'h00010, 4'hF, 36'h0);
        cyc(0, 0, 1, SEL, 17'h00011, 4'hF, 36'h0);
        flush();
        $display("test rw done");
    endtask : t_rw

    task t_burst;
        for (int k = 0; k < 2; k++) begin
            bos = k ? 1'bz : 1'b0;
            cyc(0, 0, 0, SEL, 17'h00105, 4'h0, 36'h100000000 + k);
            for (int j = 1; j < 4; j++) begin
                cyc(0, 1, j[0], SEL, 17'h1FFFF, 4'h0, 36'h200000000 + 16 * k + j);
            end
            // read back from the aligned base, where both orders walk upwards,
            // so a write burst in the wrong order shows up as a wrong word
            cyc(0, 0, 1, SEL, 17'h00104, 4'hF, '0);
            for (int j = 0; j < 4; j++) cyc(0, 1, 0, SEL, 17'h1FFFF, 4'h0, '0);
            flush();
        end
        $display("test burst done");
    endtask : t_burst

    task t_stall;
        cyc(0, 0, 1, SEL, 17'h00010, 4'hF, '0);
        cyc(1, 0, 0, SEL, 17'h00011, 4'h0, '1);
        cyc(0, 1, 1, SEL, 17'h00000, 4'hF, '0);
        cyc(1, 0, 0, 3'h0, 17'h00011, 4'h0, '1);
        cyc(1, 1, 0, SEL, 17'h00011, 4'h0, '1);
        flush();
        // a write burst whose data slots straddle disabled edges
        cyc(0, 0, 0, SEL, 17'h00012, 4'h0, 36'h3C3C3C3C3);
        cyc(1, 1, 1, SEL, 17'h00000, 4'hF, '1);
        cyc(0, 1, 1, SEL, 17'h00000, 4'h0, 36'h5A5A5A5A5);
        cyc(1, 0, 1, 3'h0, 17'h00000, 4'hF, '1);
        cyc(0, 0, 1, SEL, 17'h00012, 4'hF, '0);
        cyc(0, 1, 0, SEL, 17'h00000, 4'hF, '0);
        flush();
        $display("test stall done");
    endtask : t_stall

    task t_desel;
        logic [2:0] v [0:2] = '{3'h6, 3'h0, 3'h3};
        for (int k = 0; k < 3; k++) begin
            cyc(0, 0, 1, SEL, 17'h00011, 4'hF, '0);
            cyc(0, 0, 1, v[k], 17'h00010, 4'hF, '0);
            cyc(0, 1, 1, SEL, 17'h00010, 4'hF, '0);
            flush();
        end
        $display("test deselect done");
    endtask : t_desel

    task t_oe;
        // drivers are switched off exactly while the first read word stands
        cyc(0, 0, 1, SEL, 17'h00010, 4'hF, '0);
        cyc(0, 1, 1, SEL, 17'h00000, 4'hF, '0);
        oe_next = 1'b1;
        cyc(0, 0, 1, 3'h6, 17'h00000, 4'hF, '0);
        oe_next = 1'b0;
        flush();
        $display("test output enable done");
    endtask : t_oe

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // free-running clock, 4 ns period
    initial begin
        forever #2 clock = ~clock;
    end

    // hang guard: the whole run needs about 80 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            miscompares++;
            final_report();
        end
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        @(negedge clock);
        chk_bit(doe, 1'b0, "bus after reset");
        chk_word(dout, '0, "data after reset");
        t_rw();
        t_burst();
        t_stall();
        t_desel();
        t_oe();
        final_report();
    end
endmodule : pipelined_burst_sram_bench

/* File: sim/pipelined_burst_sram_props.sv */
`timescale 1ns/10ps
`include "burst_sram_consts.svh"

module pipelined_burst_sram_props (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // cycle controls and selects
    input wire logic clock_enable_n,
    input wire logic load_or_advance,
    input wire logic read_write_n,
    input wire logic chip_select_low_a_n,
    input wire logic chip_select_high_or_low_b,
    input wire logic chip_select_low_c_n,
    input wire logic output_enable_n,
    // data bus
    input wire logic [`SRAM_DATA_W-1:0] data_out,
    input wire logic data_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    // decoded edge kinds; all three selects must agree
    wire en = !clock_enable_n;
    wire ld = en && !load_or_advance;
    wire sel = !chip_select_low_a_n && chip_select_high_or_low_b
        && !chip_select_low_c_n;

    AST_OE_GATE: assert property (output_enable_n |-> !data_oe)
        else $error("bus driven while output enable is off");
    AST_RESET_OFF: assert property ($rose(rst_n) |-> !data_oe && data_out == '0)
        else $error("bus not quiet after reset");
    AST_FREEZE: assert property (clock_enable_n |=> $stable(data_out))
        else $error("read data moved on a disabled edge");
    AST_READ_LAT: assert property (ld && sel && read_write_n ##1 en ##1 en
        |=> data_oe || output_enable_n)
        else $error("read not driven two cycles after load");
    AST_WRITE_FLOAT: assert property (ld && sel && !read_write_n ##1 en ##1 en
        |=> !data_oe)
        else $error("bus driven in a write data slot");
    AST_DESEL_FLOAT: assert property (ld && !sel ##1 en ##1 en |=> !data_oe)
        else $error("bus not floated after deselect");
    AST_DESEL_DRAIN: assert property (ld && sel && read_write_n ##1 ld && !sel ##1 en
        |=> data_oe || output_enable_n)
        else $error("pending read lost at deselect");
    AST_RW_IGNORED: assert property (ld && sel && read_write_n
        ##1 en && load_or_advance && !read_write_n
        ##1 en ##1 en |=> data_oe || output_enable_n)
        else $error("burst direction changed on advance");
    AST_LOAD_ENDS: assert property (ld && sel && read_write_n
        ##1 ld && sel && !read_write_n ##1 en ##1 en
        |=> !data_oe)
        else $error("new load did not end the read burst");
endmodule : pipelined_burst_sram_props

bind pipelined_burst_sram pipelined_burst_sram_props i_pipelined_burst_sram_props (
    .clock, .rst_n, .clock_enable_n, .load_or_advance, .read_write_n, .chip_select_low_a_n,
    .chip_select_high_or_low_b, .chip_select_low_c_n, .output_enable_n, .data_out, .data_oe
);

/* File: verilog/burst_sram_consts.svh */
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH

// ****************************************************************
// array geometry
// ****************************************************************
`define SRAM_ADDR_W 17
`define SRAM_DEPTH 131072
`define SRAM_DATA_W 36
`define SRAM_LANES 4
`define SRAM_LANE_W 9

// ****************************************************************
// burst counter
// ****************************************************************
`define BURST_CNT_W 2
`define BURST_CNT_ZERO 2'h0
`define BURST_CNT_STEP 2'h1

// ****************************************************************
// write buffer
// ****************************************************************
`define WBUF_CNT_W 2
`define WBUF_EMPTY 2'h0
`define WBUF_ONE 2'h1
`define WBUF_FULL 2'h2

// ****************************************************************
// reset values
// ****************************************************************
`define RST_ADDR 17'h00000
`define RST_DATA 36'h000000000
`define RST_BWE_N 4'hF

`endif

/* File: verilog/burst_sram_pkg.sv */
`include "burst_sram_consts.svh"

package burst_sram_pkg;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic {
        BURST_IDLE,
        BURST_RUN
    } burst_state_t;

    // one buffered write waiting for a free array slot
    typedef struct packed {
        logic [`SRAM_ADDR_W-1:0] addr;
        logic [`SRAM_DATA_W-1:0] data;
        logic [`SRAM_LANES-1:0] bwe_n;
    } wr_entry_t;

endpackage : burst_sram_pkg

/* File: verilog/pipelined_burst_sram.sv */
`timescale 1ns/10ps
`include "burst_sram_consts.svh"

// Operation
// - sampling load_or_advance low ends any burst and captures a new address and controls.
// - while bursting with load_or_advance high, read_write_n is ignored.
// - the direction of a burst is the read_write_n value captured at its load.
// - a burst advances only the two lowest address bits, four words per base address.
// - a write begins on an edge that is selected, loading, with read_write_n low.
// - byte_write_enable_n is taken with the address, two cycles ahead of its write data.
// - clock_enable_n high at an edge with rst_n high makes the edge invisible; every register holds.
// - any chip select inactive at a loading edge starts a deselect cycle.
// - the data bus floats two cycles after a deselect cycle begins.
// - transfers already in the pipeline at a deselect still complete.
// - selection needs both active-low chip selects low and the active-high one high.
// - an undriven burst_order_select counts as high.
// - the data outputs are off after a clock edge with rst_n low.

module pipelined_burst_sram
    import burst_sram_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // cycle controls
    input wire logic clock_enable_n,
    input wire logic load_or_advance,
    input wire logic read_write_n,
    input wire logic [`SRAM_LANES-1:0] byte_write_enable_n,
    input wire logic [`SRAM_ADDR_W-1:0] address,
    // chip selects
    input wire logic chip_select_low_a_n,
    input wire logic chip_select_high_or_low_b,
    input wire logic chip_select_low_c_n,
    // static and asynchronous controls
    input wire logic burst_order_select,
    input wire logic output_enable_n,
    // data bus, split into its three signals
    input wire logic [`SRAM_DATA_W-1:0] data_in,
    output logic [`SRAM_DATA_W-1:0] data_out,
    output logic data_oe
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // burst address from base and count in the chosen order
    function automatic logic [`SRAM_ADDR_W-1:0] burst_addr(
        input logic [`SRAM_ADDR_W-1:0] base,
        input logic [`BURST_CNT_W-1:0] cnt,
        input logic linear
    );
        logic [`BURST_CNT_W-1:0] low;
        low = base[`BURST_CNT_W-1:0];
        if (linear) begin
            low = low + cnt;
        end else begin
            low = low ^ cnt;
        end
        return {base[`SRAM_ADDR_W-1:`BURST_CNT_W], low};
    endfunction : burst_addr

    // lay the enabled lanes of a buffered write over older data
    function automatic logic [`SRAM_DATA_W-1:0] overlay(
        input logic [`SRAM_DATA_W-1:0] old,
        input wr_entry_t e,
        input logic hit
    );
        logic [`SRAM_DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < `SRAM_LANES; i++) begin
            if (hit && !e.bwe_n[i]) begin
                res[i*`SRAM_LANE_W +: `SRAM_LANE_W] = e.data[i*`SRAM_LANE_W +: `SRAM_LANE_W];
            end
        end
        return res;
    endfunction : overlay

    // ****************************************************************
    // decode of the pins
    // ****************************************************************
    logic enabled;
    logic selected;
    logic linear_order;

    assign enabled = !clock_enable_n;
    assign selected = !chip_select_low_a_n && chip_select_high_or_low_b
        && !chip_select_low_c_n;
    // only a driven low picks linear order, so a floating pin reads as high
    assign linear_order = (burst_order_select === 1'b0);

    // ****************************************************************
    // burst counter and capture stage
    // ****************************************************************
    burst_state_t state_q, state_d;
    logic [`SRAM_ADDR_W-1:0] base_q, base_d;
    logic [`BURST_CNT_W-1:0] cnt_q, cnt_d;
    logic dir_write_q, dir_write_d;
    logic s1_valid_q, s1_valid_d;
    logic s1_write_q, s1_write_d;
    logic [`SRAM_ADDR_W-1:0] s1_addr_q, s1_addr_d;
    logic [`SRAM_LANES-1:0] s1_bwe_n_q, s1_bwe_n_d;

    // a load decides select and direction; an advance only moves the low bits
    always_comb begin
        state_d = state_q;
        base_d = base_q;
        cnt_d = cnt_q;
        dir_write_d = dir_write_q;
        s1_valid_d = s1_valid_q;
        s1_write_d = s1_write_q;
        s1_addr_d = s1_addr_q;
        s1_bwe_n_d = s1_bwe_n_q;
        if (enabled) begin
            if (!load_or_advance) begin
                base_d = address;
                cnt_d = `BURST_CNT_ZERO;
                dir_write_d = !read_write_n;
                state_d = selected ? BURST_RUN : BURST_IDLE;
                s1_valid_d = selected;
                s1_write_d = !read_write_n;
                s1_addr_d = address;
                s1_bwe_n_d = byte_write_enable_n;
            end else begin
                case (state_q)
                    BURST_RUN: begin
                        // read_write_n is not looked at here
                        cnt_d = cnt_q + `BURST_CNT_STEP;
                        s1_valid_d = 1'b1;
                        s1_write_d = dir_write_q;
                        s1_addr_d = burst_addr(base_q, cnt_d, linear_order);
                        s1_bwe_n_d = byte_write_enable_n;
                    end
                    BURST_IDLE: begin
                        s1_valid_d = 1'b0;
                    end
                    default: begin
                        state_d = BURST_IDLE;
                        s1_valid_d = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= BURST_IDLE;
            base_q <= `RST_ADDR;
            cnt_q <= `BURST_CNT_ZERO;
            dir_write_q <= 1'b0;
            s1_valid_q <= 1'b0;
            s1_write_q <= 1'b0;
            s1_addr_q <= `RST_ADDR;
            s1_bwe_n_q <= `RST_BWE_N;
        end else begin
            state_q <= state_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            dir_write_q <= dir_write_d;
            s1_valid_q <= s1_valid_d;
            s1_write_q <= s1_write_d;
            s1_addr_q <= s1_addr_d;
            s1_bwe_n_q <= s1_bwe_n_d;
        end
    end

    // ****************************************************************
    // second pipeline stage
    // ****************************************************************
    logic s2_valid_q, s2_valid_d;
    logic s2_write_q, s2_write_d;
    logic [`SRAM_ADDR_W-1:0] s2_addr_q, s2_addr_d;
    logic [`SRAM_LANES-1:0] s2_bwe_n_q, s2_bwe_n_d;

    // a deselect only clears the new slot; older ones keep moving
    always_comb begin
        s2_valid_d = s2_valid_q;
        s2_write_d = s2_write_q;
        s2_addr_d = s2_addr_q;
        s2_bwe_n_d = s2_bwe_n_q;
        if (enabled) begin
            s2_valid_d = s1_valid_q;
            s2_write_d = s1_write_q;
            s2_addr_d = s1_addr_q;
            s2_bwe_n_d = s1_bwe_n_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s2_valid_q <= 1'b0;
            s2_write_q <= 1'b0;
            s2_addr_q <= `RST_ADDR;
            s2_bwe_n_q <= `RST_BWE_N;
        end else begin
            s2_valid_q <= s2_valid_d;
            s2_write_q <= s2_write_d;
            s2_addr_q <= s2_addr_d;
            s2_bwe_n_q <= s2_bwe_n_d;
        end
    end

    // ****************************************************************
    // two-entry write buffer
    // ****************************************************************
    wr_entry_t wbuf_q [0:1];
    wr_entry_t wbuf_d [0:1];
    logic [`WBUF_CNT_W-1:0] wcnt_q, wcnt_d;
    wr_entry_t push_entry;
    logic rd_issue;
    logic push_valid;
    logic push_ready;
    logic pop;

    // reads own the array port; buffered writes fill the idle slots
    assign rd_issue = enabled && s1_valid_q && !s1_write_q;
    assign pop = enabled && (wcnt_q != `WBUF_EMPTY) && !rd_issue;
    assign push_valid = enabled && s2_valid_q && s2_write_q;
    // every write frees an array slot one cycle before its data arrive,
    // so the buffer cannot overflow; a full buffer refuses the word
    assign push_ready = (wcnt_q != `WBUF_FULL) || pop;
    assign push_entry = '{addr: s2_addr_q, data: data_in, bwe_n: s2_bwe_n_q};

    // oldest entry sits in slot zero
    always_comb begin
        wbuf_d[0] = wbuf_q[0];
        wbuf_d[1] = wbuf_q[1];
        wcnt_d = wcnt_q;
        if (pop) begin
            wbuf_d[0] = wbuf_q[1];
            wcnt_d = wcnt_q - `WBUF_ONE;
        end
        if (push_valid && push_ready) begin
            if (wcnt_d == `WBUF_EMPTY) begin
                wbuf_d[0] = push_entry;
            end else begin
                wbuf_d[1] = push_entry;
            end
            wcnt_d = wcnt_d + `WBUF_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wbuf_q[0] <= '{addr: `RST_ADDR, data: `RST_DATA, bwe_n: `RST_BWE_N};
            wbuf_q[1] <= '{addr: `RST_ADDR, data: `RST_DATA, bwe_n: `RST_BWE_N};
            wcnt_q <= `WBUF_EMPTY;
        end else begin
            wbuf_q[0] <= wbuf_d[0];
            wbuf_q[1] <= wbuf_d[1];
            wcnt_q <= wcnt_d;
        end
    end

    // ****************************************************************
    // storage array
    // ****************************************************************
    logic [`SRAM_DATA_W-1:0] rd_data;

    sram_array i_sram_array (
        .clock(clock),
        .rd_en(rd_issue),
        .rd_addr(s1_addr_q),
        .rd_data(rd_data),
        .wr_en(pop),
        .wr_addr(wbuf_q[0].addr),
        .wr_data(wbuf_q[0].data),
        .wr_bwe_n(wbuf_q[0].bwe_n)
    );

    // ****************************************************************
    // output register and drivers
    // ****************************************************************
    logic drive_q, drive_d;
    logic [`SRAM_DATA_W-1:0] dout_q, dout_d;
    logic hit0;
    logic hit1;

    // writes still buffered must win over the stale array word
    assign hit0 = (wcnt_q != `WBUF_EMPTY) && (wbuf_q[0].addr == s2_addr_q);
    assign hit1 = (wcnt_q == `WBUF_FULL) && (wbuf_q[1].addr == s2_addr_q);

    // drivers turn on only for a read two cycles after its capture
    always_comb begin
        drive_d = drive_q;
        dout_d = dout_q;
        if (enabled) begin
            drive_d = s2_valid_q && !s2_write_q;
            if (s2_valid_q && !s2_write_q) begin
                dout_d = overlay(overlay(rd_data, wbuf_q[0], hit0), wbuf_q[1], hit1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            drive_q <= 1'b0;
            dout_q <= `RST_DATA;
        end else begin
            drive_q <= drive_d;
            dout_q <= dout_d;
        end
    end

    assign data_out = dout_q;
    // output enable gates only the drivers, never the pipeline
    assign data_oe = drive_q && !output_enable_n;

endmodule : pipelined_burst_sram

/* File: verilog/sram_array.sv */
`timescale 1ns/10ps
`include "burst_sram_consts.svh"

module sram_array (
    // clock
    input wire logic clock,
    // read port, data registered
    input wire logic rd_en,
    input wire logic [`SRAM_ADDR_W-1:0] rd_addr,
    output logic [`SRAM_DATA_W-1:0] rd_data,
    // write port with active-low lane enables
    input wire logic wr_en,
    input wire logic [`SRAM_ADDR_W-1:0] wr_addr,
    input wire logic [`SRAM_DATA_W-1:0] wr_data,
    input wire logic [`SRAM_LANES-1:0] wr_bwe_n
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [`SRAM_DATA_W-1:0] mem [0:`SRAM_DEPTH-1];

    // read data held until the next read so a stalled pipeline sees no change
    always_ff @(posedge clock) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

    // lane-wise write; the caller never reads and writes in the same cycle
    always_ff @(posedge clock) begin
        for (int i = 0; i < `SRAM_LANES; i++) begin
            if (wr_en && !wr_bwe_n[i]) begin
                mem[wr_addr][i*`SRAM_LANE_W +: `SRAM_LANE_W] <=
                    wr_data[i*`SRAM_LANE_W +: `SRAM_LANE_W];
            end
        end
    end

endmodule : sram_array
